// file: rtl/bss_pkg.sv
// Package of timing constants, state codes and flash codes for the sequencer.
package bss_pkg;

  // Core clock rate and the derived length of the 1 ms timing tick.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Sequence times in seconds, as specified.
  localparam int unsigned AIR_LIMIT_S = 60;
  localparam int unsigned PREPURGE_S = 24;
  localparam int unsigned PREIGN_S = 3;
  localparam int unsigned POSTIGN_S = 4;
  localparam int unsigned STRAY_S = 5;
  localparam int unsigned SAFETY_S = 5;
  localparam int unsigned DELAY2_S = 10;
  localparam int unsigned HOLD_S = 3;

  // Sequence times as counts of 1 ms ticks.
  localparam logic [15:0] AIR_LIMIT_MS = 16'(AIR_LIMIT_S * 1000);
  localparam logic [15:0] PREPURGE_MS = 16'(PREPURGE_S * 1000);
  localparam logic [15:0] PREIGN_MS = 16'(PREIGN_S * 1000);
  localparam logic [15:0] POSTIGN_MS = 16'(POSTIGN_S * 1000);
  localparam logic [15:0] STRAY_START_MS = 16'((PREPURGE_S - STRAY_S) * 1000);
  localparam logic [15:0] SAFETY_MS = 16'(SAFETY_S * 1000);
  localparam logic [15:0] DELAY2_MS = 16'(DELAY2_S * 1000);
  localparam logic [11:0] HOLD_MS = 12'(HOLD_S * 1000);
  localparam logic [11:0] HOLD_MAX = 12'hfff;
  localparam logic [15:0] MS_MAX = 16'hffff;

  // Indicator element lengths in ms.
  localparam logic [13:0] LED_SHORT_MS = 14'd300;
  localparam logic [13:0] LED_LONG_MS = 14'd900;
  localparam logic [13:0] LED_SPACE_MS = 14'd300;
  localparam logic [13:0] LED_TAIL_MS = 14'd1200;
  localparam logic [13:0] LED_STEADY_MS = 14'd10000;
  localparam logic [13:0] LED_GAP_MS = 14'd600;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_BOOT = 4'h0,
    ST_IDLE = 4'h1,
    ST_AIR_WAIT = 4'h2,
    ST_PREPURGE = 4'h3,
    ST_PREIGN = 4'h4,
    ST_SAFETY = 4'h5,
    ST_DELAY2 = 4'h6,
    ST_RUN = 4'h7,
    ST_UNDERV = 4'h8,
    ST_LOCK = 4'h9
  } bss_state_e;

  // Indicator engine states.
  typedef enum logic [2:0] {
    LS_START = 3'h0,
    LS_STEADY = 3'h1,
    LS_GAP = 3'h2,
    LS_PULSE = 3'h3,
    LS_SPACE = 3'h4,
    LS_TAIL = 3'h5
  } bss_led_e;

  // Lockout causes, also the value kept in nonvolatile storage.
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_SAFETY = 3'h1;
  localparam logic [2:0] CAUSE_STRAY = 3'h2;
  localparam logic [2:0] CAUSE_AIR_CLOSED = 3'h3;
  localparam logic [2:0] CAUSE_AIR_TIMEOUT = 3'h4;
  localparam logic [2:0] CAUSE_AIR_OPENED = 3'h5;
  localparam logic [2:0] CAUSE_FLAME_LOSS = 3'h6;
  localparam logic [2:0] CAUSE_MANUAL = 3'h7;

  // Flash codes: {length[2:0], long mask[3:0]}, mask bit i marks pulse i long.
  localparam logic [6:0] CODE_OFF = 7'h00;
  localparam logic [6:0] CODE_AIR_WAIT = 7'h20;
  localparam logic [6:0] CODE_PREPURGE = 7'h30;
  localparam logic [6:0] CODE_PREIGN = 7'h40;
  localparam logic [6:0] CODE_SAFETY = 7'h21;
  localparam logic [6:0] CODE_DELAY2 = 7'h22;
  localparam logic [6:0] CODE_RUN = 7'h11;
  localparam logic [6:0] CODE_UNDERV = 7'h23;
  localparam logic [6:0] CODE_F_SAFETY = 7'h31;
  localparam logic [6:0] CODE_F_STRAY = 7'h32;
  localparam logic [6:0] CODE_F_AIR_CLOSED = 7'h34;
  localparam logic [6:0] CODE_F_AIR_TIMEOUT = 7'h33;
  localparam logic [6:0] CODE_F_AIR_OPENED = 7'h36;
  localparam logic [6:0] CODE_F_FLAME_LOSS = 7'h35;
  localparam logic [6:0] CODE_F_MANUAL = 7'h37;

endpackage

// file: rtl/bss_sequencer.sv
// Start sequencer, supervision, lockout memory and flash-code indicator.
`timescale 1ns/10ps

// Behaviour
// - Phase times: air 60 s, purge 24 s, pre 3, post 4, stray 5, safety 5, delay 10.
// - Outside idle and lockout, LED shows phase code: one to four short or long pulses.
// - LED messages are built from short and long pulses with short and long pauses.
// - A latched lockout holds the LED steadily lit instead of phase codes.
// - In lockout, after each 10 s of steady light the LED breaks for the cause code.
// - No flame at end of safety time locks out with safety cause.
// - Flame during the stray light window locks out with stray cause.
// - Air switch not closed within 60 s of motor start locks out.
// - Air switch opening during start or running locks out at once.
// - Flame loss while running locks out directly with no restart.
// - Stray light check covers the last 5 s of pre-purge.
// - Lockout cause goes to nonvolatile storage and returns after power loss.
// - Undervoltage stops operation and blocks restart while it persists.
// - Reset press during lockout clears it and starts a new cycle.
// - Reset held over 3 s in sequence or running, then released, locks out.
module bss_sequencer #(
  parameter int unsigned TICK_CYCLES = bss_pkg::TICK_CYCLES
) (
  input wire logic i_core_clk, // Core clock, 20 MHz.
  input wire logic i_rst_b, // Asynchronous reset, active low.
  input wire logic i_heat_demand, // Thermostat chain closed.
  input wire logic i_air_switch, // Air proving switch closed.
  input wire logic i_flame, // Flame signal present.
  input wire logic i_undervoltage, // Mains below permitted level.
  input wire logic i_reset_button, // Reset button pressed.
  input wire logic [2:0] i_nv_cause, // Cause read from nonvolatile store.
  output logic o_motor, // Burner fan motor on.
  output logic o_ignition, // Ignition transformer on.
  output logic o_valve1, // First-stage valve open.
  output logic o_valve2, // Second-stage valve open.
  output logic o_alarm, // Lockout alarm output.
  output logic o_led, // Indicator LED lit.
  output logic o_nv_we, // One-cycle write strobe to the store.
  output logic [2:0] o_nv_cause // Cause written to the store.
);

  // Whole state of the block.
  typedef struct packed {
    bss_pkg::bss_state_e st;
    logic [2:0] cause;
    logic [15:0] tick_cnt;
    logic [15:0] ms;
    logic btn;
    logic [11:0] hold;
    bss_pkg::bss_led_e lst;
    logic lmode;
    logic [13:0] lcnt;
    logic [2:0] lidx;
    logic [2:0] llen;
    logic [3:0] lmask;
    logic motor;
    logic ign;
    logic v1;
    logic v2;
    logic alarm;
    logic led;
    logic nv_we;
    logic [2:0] nv_cause;
  } bss_state_s;

  bss_state_s q;
  bss_state_s d;

  // Flash code for a sequence phase.
  function automatic logic [6:0] phase_code(input bss_pkg::bss_state_e s);
    case (s)
      bss_pkg::ST_AIR_WAIT: phase_code = bss_pkg::CODE_AIR_WAIT;
      bss_pkg::ST_PREPURGE: phase_code = bss_pkg::CODE_PREPURGE;
      bss_pkg::ST_PREIGN: phase_code = bss_pkg::CODE_PREIGN;
      bss_pkg::ST_SAFETY: phase_code = bss_pkg::CODE_SAFETY;
      bss_pkg::ST_DELAY2: phase_code = bss_pkg::CODE_DELAY2;
      bss_pkg::ST_RUN: phase_code = bss_pkg::CODE_RUN;
      bss_pkg::ST_UNDERV: phase_code = bss_pkg::CODE_UNDERV;
      default: phase_code = bss_pkg::CODE_OFF;
    endcase
  endfunction

  // Flash code for a lockout cause.
  function automatic logic [6:0] fault_code(input logic [2:0] c);
    case (c)
      bss_pkg::CAUSE_SAFETY: fault_code = bss_pkg::CODE_F_SAFETY;
      bss_pkg::CAUSE_STRAY: fault_code = bss_pkg::CODE_F_STRAY;
      bss_pkg::CAUSE_AIR_CLOSED: fault_code = bss_pkg::CODE_F_AIR_CLOSED;
      bss_pkg::CAUSE_AIR_TIMEOUT: fault_code = bss_pkg::CODE_F_AIR_TIMEOUT;
      bss_pkg::CAUSE_AIR_OPENED: fault_code = bss_pkg::CODE_F_AIR_OPENED;
      bss_pkg::CAUSE_FLAME_LOSS: fault_code = bss_pkg::CODE_F_FLAME_LOSS;
      bss_pkg::CAUSE_MANUAL: fault_code = bss_pkg::CODE_F_MANUAL;
      default: fault_code = bss_pkg::CODE_OFF;
    endcase
  endfunction

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  logic tick;
  logic press;
  logic release_ev;
  logic active;
  logic lock_req;
  logic [2:0] lock_cause;
  logic [6:0] code;
  logic [13:0] ldur;
  logic ldone;

  // Sequencer, supervision and indicator next-state logic.
  always_comb begin
    d = q;
    d.nv_we = 1'b0;
    lock_req = 1'b0;
    lock_cause = bss_pkg::CAUSE_NONE;
    tick = (q.tick_cnt == TICK_LAST);
    d.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
    if (tick && q.ms != bss_pkg::MS_MAX) begin
      d.ms = q.ms + 16'h0001;
    end
    press = i_reset_button & ~q.btn;
    release_ev = ~i_reset_button & q.btn;
    d.btn = i_reset_button;
    // Hold time of the reset button, restarted at each press.
    if (press) begin
      d.hold = 12'h000;
    end else if (i_reset_button && tick && q.hold != bss_pkg::HOLD_MAX) begin
      d.hold = q.hold + 12'h001;
    end
    active = (q.st >= bss_pkg::ST_AIR_WAIT) && (q.st <= bss_pkg::ST_RUN);

    // Phase sequence with its faults.
    case (q.st)
      bss_pkg::ST_BOOT: begin
        if (i_nv_cause != bss_pkg::CAUSE_NONE) begin
          d.st = bss_pkg::ST_LOCK;
          d.cause = i_nv_cause;
          d.ms = 16'h0000;
        end else begin
          d.st = bss_pkg::ST_IDLE;
          d.ms = 16'h0000;
        end
      end
      bss_pkg::ST_IDLE: begin
        if (i_undervoltage) begin
          d.st = bss_pkg::ST_UNDERV;
          d.ms = 16'h0000;
        end else if (i_heat_demand) begin
          if (i_air_switch) begin
            lock_req = 1'b1;
            lock_cause = bss_pkg::CAUSE_AIR_CLOSED;
          end else begin
            d.st = bss_pkg::ST_AIR_WAIT;
            d.ms = 16'h0000;
          end
        end
      end
      bss_pkg::ST_AIR_WAIT: begin
        if (i_air_switch) begin
          d.st = bss_pkg::ST_PREPURGE;
          d.ms = 16'h0000;
        end else if (q.ms >= bss_pkg::AIR_LIMIT_MS) begin
          lock_req = 1'b1;
          lock_cause = bss_pkg::CAUSE_AIR_TIMEOUT;
        end
      end
      bss_pkg::ST_PREPURGE: begin
        if (!i_air_switch) begin
          lock_req = 1'b1;
          lock_cause = bss_pkg::CAUSE_AIR_OPENED;
        end else if (q.ms >= bss_pkg::STRAY_START_MS && i_flame) begin
          lock_req = 1'b1;
          lock_cause = bss_pkg::CAUSE_STRAY;
        end else if (q.ms >= bss_pkg::PREPURGE_MS) begin
          d.st = bss_pkg::ST_PREIGN;
          d.ms = 16'h0000;
        end
      end
      bss_pkg::ST_PREIGN: begin
        if (!i_air_switch) begin
          lock_req = 1'b1;
          lock_cause = bss_pkg::CAUSE_AIR_OPENED;
        end else if (q.ms >= bss_pkg::PREIGN_MS) begin
          d.st = bss_pkg::ST_SAFETY;
          d.ms = 16'h0000;
        end
      end
      bss_pkg::ST_SAFETY: begin
        if (!i_air_switch) begin
          lock_req = 1'b1;
          lock_cause = bss_pkg::CAUSE_AIR_OPENED;
        end else if (q.ms >= bss_pkg::SAFETY_MS) begin
          if (i_flame) begin
            d.st = bss_pkg::ST_DELAY2;
            d.ms = 16'h0000;
          end else begin
            lock_req = 1'b1;
            lock_cause = bss_pkg::CAUSE_SAFETY;
          end
        end
      end
      bss_pkg::ST_DELAY2, bss_pkg::ST_RUN: begin
        if (!i_air_switch) begin
          lock_req = 1'b1;
          lock_cause = bss_pkg::CAUSE_AIR_OPENED;
        end else if (!i_flame) begin
          lock_req = 1'b1;
          lock_cause = bss_pkg::CAUSE_FLAME_LOSS;
        end else if (q.st == bss_pkg::ST_DELAY2 &&
                     q.ms >= bss_pkg::DELAY2_MS) begin
          d.st = bss_pkg::ST_RUN;
          d.ms = 16'h0000;
        end else if (q.st == bss_pkg::ST_RUN && !i_heat_demand) begin
          d.st = bss_pkg::ST_IDLE;
          d.ms = 16'h0000;
        end
      end
      bss_pkg::ST_UNDERV: begin
        if (!i_undervoltage) begin
          d.st = bss_pkg::ST_IDLE;
          d.ms = 16'h0000;
        end
      end
      bss_pkg::ST_LOCK: begin
        if (press) begin
          d.st = bss_pkg::ST_IDLE;
          d.ms = 16'h0000;
          d.cause = bss_pkg::CAUSE_NONE;
          d.nv_we = 1'b1;
          d.nv_cause = bss_pkg::CAUSE_NONE;
        end
      end
      default: begin
        d.st = bss_pkg::ST_BOOT;
      end
    endcase

    // Demand loss during start ends the attempt quietly.
    if (active && q.st != bss_pkg::ST_RUN && !i_heat_demand && !lock_req) begin
      d.st = bss_pkg::ST_IDLE;
      d.ms = 16'h0000;
    end
    // Long press released during start or running forces a lockout.
    if (active && release_ev && q.hold > bss_pkg::HOLD_MS) begin
      lock_req = 1'b1;
      lock_cause = bss_pkg::CAUSE_MANUAL;
    end
    // Undervoltage overrides every running phase.
    if (active && i_undervoltage) begin
      lock_req = 1'b0;
      d.st = bss_pkg::ST_UNDERV;
      d.ms = 16'h0000;
    end
    // Entry into lockout stores the cause.
    if (lock_req) begin
      d.st = bss_pkg::ST_LOCK;
      d.ms = 16'h0000;
      d.cause = lock_cause;
      d.nv_we = 1'b1;
      d.nv_cause = lock_cause;
    end

    // Loads follow the next phase and its elapsed time.
    d.motor = (d.st >= bss_pkg::ST_AIR_WAIT) && (d.st <= bss_pkg::ST_RUN);
    d.ign = (d.st == bss_pkg::ST_PREIGN) ||
            (d.st == bss_pkg::ST_SAFETY && d.ms < bss_pkg::POSTIGN_MS);
    d.v1 = (d.st >= bss_pkg::ST_SAFETY) && (d.st <= bss_pkg::ST_RUN);
    d.v2 = (d.st == bss_pkg::ST_RUN);
    d.alarm = (d.st == bss_pkg::ST_LOCK);

    // Indicator message engine.
    code = (q.st == bss_pkg::ST_LOCK) ? fault_code(q.cause) :
           phase_code(q.st);
    case (q.lst)
      bss_pkg::LS_STEADY: ldur = bss_pkg::LED_STEADY_MS;
      bss_pkg::LS_GAP: ldur = bss_pkg::LED_GAP_MS;
      bss_pkg::LS_PULSE: ldur = q.lmask[q.lidx[1:0]] ?
                         bss_pkg::LED_LONG_MS : bss_pkg::LED_SHORT_MS;
      bss_pkg::LS_SPACE: ldur = bss_pkg::LED_SPACE_MS;
      bss_pkg::LS_TAIL: ldur = bss_pkg::LED_TAIL_MS;
      default: ldur = 14'h0001;
    endcase
    ldone = tick && (q.lcnt >= ldur - 14'h0001);
    if (tick) begin
      d.lcnt = ldone ? 14'h0000 : q.lcnt + 14'h0001;
    end
    if (q.lmode != (q.st == bss_pkg::ST_LOCK)) begin
      d.lst = bss_pkg::LS_START;
      d.lcnt = 14'h0000;
      d.lmode = (q.st == bss_pkg::ST_LOCK);
    end else begin
      case (q.lst)
        bss_pkg::LS_START: begin
          d.llen = code[6:4];
          d.lmask = code[3:0];
          d.lidx = 3'h0;
          d.lcnt = 14'h0000;
          if (q.lmode) begin
            d.lst = bss_pkg::LS_STEADY;
          end else if (code[6:4] != 3'h0) begin
            d.lst = bss_pkg::LS_PULSE;
          end
        end
        bss_pkg::LS_STEADY: begin
          if (ldone) begin
            d.lst = bss_pkg::LS_GAP;
          end
        end
        bss_pkg::LS_GAP: begin
          if (ldone) begin
            d.lst = bss_pkg::LS_PULSE;
          end
        end
        bss_pkg::LS_PULSE: begin
          if (ldone) begin
            d.lst = (q.lidx == q.llen - 3'h1) ? bss_pkg::LS_TAIL :
                    bss_pkg::LS_SPACE;
          end
        end
        bss_pkg::LS_SPACE: begin
          if (ldone) begin
            d.lidx = q.lidx + 3'h1;
            d.lst = bss_pkg::LS_PULSE;
          end
        end
        bss_pkg::LS_TAIL: begin
          if (ldone) begin
            d.lst = bss_pkg::LS_START;
          end
        end
        default: begin
          d.lst = bss_pkg::LS_START;
        end
      endcase
    end
    d.led = (d.lst == bss_pkg::LS_STEADY) || (d.lst == bss_pkg::LS_PULSE);
  end

  // State register.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign o_motor = q.motor;
  assign o_ignition = q.ign;
  assign o_valve1 = q.v1;
  assign o_valve2 = q.v2;
  assign o_alarm = q.alarm;
  assign o_led = q.led;
  assign o_nv_we = q.nv_we;
  assign o_nv_cause = q.nv_cause;

endmodule

// file: test/bss_checker.sv
// Concurrent checks on the burner start sequencer ports.
`timescale 1ns/10ps
module bss_checker #(
  parameter int unsigned TICK_CYCLES = 1 // Clocks per timing tick.
) (
  input wire logic i_core_clk, // Clock.
  input wire logic i_rst_b, // Reset, active low.
  input wire logic i_heat_demand, // Demand.
  input wire logic i_air_switch, // Air proven.
  input wire logic i_flame, // Flame.
  input wire logic i_undervoltage, // Mains low.
  input wire logic i_reset_button, // Button.
  input wire logic [2:0] i_nv_cause, // Stored cause.
  input wire logic o_motor, // Fan.
  input wire logic o_ignition, // Ignition.
  input wire logic o_valve1, // Valve 1.
  input wire logic o_valve2, // Valve 2.
  input wire logic o_alarm, // Alarm.
  input wire logic o_led, // LED.
  input wire logic o_nv_we, // Store strobe.
  input wire logic [2:0] o_nv_cause // Store data.
);
  // All checks run on the core clock and rest during reset.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  // A latched lockout leaves every load off.
  property p_lock_off;
    o_alarm |-> !(o_motor | o_ignition | o_valve1 | o_valve2);
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("load on during lockout");
  // The second stage only opens behind the first.
  property p_v2_v1;
    o_valve2 |-> o_valve1;
  endproperty
  a_v2_v1: assert property (p_v2_v1)
    else $error("second valve without first");
  // Ignition still burns when the first valve opens.
  property p_v1_ign;
    $rose(o_valve1) |-> o_ignition;
  endproperty
  a_v1_ign: assert property (p_v1_ign)
    else $error("first valve opened without ignition");
  // A stored nonzero cause always comes with the alarm.
  property p_nv_alarm;
    o_nv_we |-> (o_alarm == (o_nv_cause != 3'h0));
  endproperty
  a_nv_alarm: assert property (p_nv_alarm)
    else $error("store write disagrees with alarm");
  // A lockout from a running start is written to the store.
  property p_nv_write;
    $rose(o_alarm) && $past(o_motor) |-> o_nv_we && o_nv_cause != 3'h0;
  endproperty
  a_nv_write: assert property (p_nv_write)
    else $error("lockout cause not stored");
  // A fresh lockout lights the indicator steadily.
  property p_led_steady;
    $rose(o_alarm) && o_nv_we |-> ##2 o_led [*8];
  endproperty
  a_led_steady: assert property (p_led_steady)
    else $error("indicator not steady in lockout");
  // Air contact opening with the fan on locks out next cycle.
  property p_air_open;
    o_motor && $fell(i_air_switch) && i_heat_demand && !i_undervoltage
      |=> o_alarm && o_nv_cause == bss_pkg::CAUSE_AIR_OPENED;
  endproperty
  a_air_open: assert property (p_air_open)
    else $error("no lockout on air contact opening");
  // Flame loss while running locks out at once.
  property p_flame_loss;
    o_valve2 && $fell(i_flame) && i_air_switch && i_heat_demand &&
      !i_undervoltage |=> o_alarm && o_nv_cause == bss_pkg::CAUSE_FLAME_LOSS;
  endproperty
  a_flame_loss: assert property (p_flame_loss)
    else $error("no lockout on flame loss");
  // A button press in lockout clears it and the store.
  property p_unlock;
    o_alarm && $rose(i_reset_button)
      |=> !o_alarm && o_nv_we && o_nv_cause == bss_pkg::CAUSE_NONE;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("button did not clear lockout");
  // Low mains drops every load on the next cycle.
  property p_underv;
    i_undervoltage |=> !(o_motor | o_ignition | o_valve1 | o_valve2);
  endproperty
  a_underv: assert property (p_underv)
    else $error("load on during low mains");
endmodule

bind bss_sequencer bss_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .i_core_clk, .i_rst_b, .i_heat_demand, .i_air_switch, .i_flame,
  .i_undervoltage, .i_reset_button, .i_nv_cause, .o_motor, .o_ignition,
  .o_valve1, .o_valve2, .o_alarm, .o_led, .o_nv_we, .o_nv_cause
);

// file: test/bss_plant.sv
// Model of the burner plant: fan air contact and flame detector.
`timescale 1ns/10ps
module bss_plant (
  input wire logic i_core_clk, // Clock.
  input wire logic i_motor, // Fan running.
  input wire logic i_valve1, // Fuel valve open.
  input wire logic i_fuel_ok, // Fuel reaches the burner.
  input wire logic i_stray, // Stray light present.
  input wire logic i_air_break, // Air duct blocked.
  input wire logic i_air_weld, // Air contact stuck closed.
  input wire logic [7:0] i_air_dly, // Cycles until air proves.
  output logic o_air_switch, // Air proving contact.
  output logic o_flame // Flame detected.
);
  logic [7:0] run_q = 8'h00;
  logic [2:0] fire_q = 3'h0;
  // Air proves some cycles after fan start; flame trails the fuel.
  always_ff @(posedge i_core_clk) begin
    run_q <= !i_motor ? 8'h00 : (run_q == 8'hff ? run_q : run_q + 8'h01);
    fire_q <= {fire_q[1:0], i_valve1 & i_fuel_ok};
  end
  // Unless welded, the contact opens as soon as the fan stops or the duct is blocked.
  assign o_air_switch = i_air_weld |
    (i_motor && !i_air_break && run_q >= i_air_dly);
  assign o_flame = i_stray | fire_q[2];
endmodule

// file: test/test_bss_sequencer.sv
// Self-checking bench for the burner start sequencer.
`timescale 1ns/10ps
module test_bss_sequencer;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_heat_demand = 1'b0;
  logic i_undervoltage = 1'b0;
  logic i_reset_button = 1'b0;
  logic [2:0] i_nv_cause = 3'h0;
  logic [2:0] nv_store = 3'h0;
  logic i_air_switch, i_flame, o_motor, o_ignition, o_valve1, o_valve2;
  logic o_alarm, o_led, o_nv_we;
  logic [2:0] o_nv_cause;
  logic fuel_ok = 1'b1, stray = 1'b0, air_break = 1'b0, air_weld = 1'b0;
  logic [7:0] air_dly = 8'h10;
  logic [6:0] code;
  int err_count = 0, n_tests = 0, cyc = 0, t;
  wire logic [4:0] obs = {o_motor, o_ignition, o_valve1, o_valve2, o_alarm};

  bss_sequencer #(.TICK_CYCLES(1)) dut_u (
    .i_core_clk, .i_rst_b, .i_heat_demand, .i_air_switch, .i_flame,
    .i_undervoltage, .i_reset_button, .i_nv_cause, .o_motor, .o_ignition,
    .o_valve1, .o_valve2, .o_alarm, .o_led, .o_nv_we, .o_nv_cause);
  bss_plant plant_u (.i_core_clk, .i_motor(o_motor), .i_valve1(o_valve1),
    .i_fuel_ok(fuel_ok), .i_stray(stray), .i_air_break(air_break),
    .i_air_weld(air_weld), .i_air_dly(air_dly),
    .o_air_switch(i_air_switch), .o_flame(i_flame));

  // Clock of 50 ns period.
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end
  // Nonvolatile store kept across resets, and the hang limit.
  always @(posedge i_core_clk) begin
    if (o_nv_we === 1'b1) nv_store <= o_nv_cause;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      $display("unexpected timeout expected 0 seen 1");
      tally_and_finish();
    end
  end

  function automatic int ms(input int s);
    return s * 1000;
  endfunction
  task automatic check(input string what, input logic [6:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic near(input string what, input int k, input int e);
    check(what, 7'(k >= e - 3 && k <= e + 3), 7'h1);
  endtask
  task automatic cw(input int k);
    repeat (k) @(negedge i_core_clk);
  endtask
  task automatic wait_bit(input int i, input logic v);
    while (obs[i] !== v) @(negedge i_core_clk);
  endtask
  task automatic press(input int k);
    i_reset_button = 1'b1;
    cw(k);
    i_reset_button = 1'b0;
    cw(2);
  endtask
  task automatic do_reset(input logic [2:0] nv);
    i_nv_cause = nv;
    i_rst_b = 1'b0;
    cw(4);
    i_rst_b = 1'b1;
    cw(3);
  endtask
  // Reads one flash message as {pulse count, long mask} after a dark gap.
  task automatic read_msg(output logic [6:0] c);
    int lo, hi, np;
    logic [3:0] m;
    lo = 0;
    hi = 0;
    np = 0;
    m = 4'h0;
    while (lo < 500) begin
      @(negedge i_core_clk);
      lo = o_led ? 0 : lo + 1;
    end
    lo = 0;
    while (np == 0 || lo < 500) begin
      @(negedge i_core_clk);
      if (o_led) begin
        hi++;
        lo = 0;
      end else begin
        if (hi > 0) begin
          m[np] = hi > 600;
          np++;
        end
        hi = 0;
        lo++;
      end
    end
    c = {3'(np), m};
  endtask
  // Drops demand and clears a lockout with a short press.
  task automatic clear(input string name);
    i_heat_demand = 1'b0;
    air_weld = 1'b0;
    air_break = 1'b0;
    stray = 1'b0;
    press(5);
    check("unlocked", o_alarm, 7'h0);
    $display("test %s done", name);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'hea9f1b7c));
    do_reset(3'($urandom_range(7, 1)));
    check("boot lock", o_alarm, 7'h1);
    clear("boot lock");
    check("store cleared", nv_store, 7'h0);
    air_weld = 1'b1;
    i_heat_demand = 1'b1;
    cw(3);
    check("welded cause", o_nv_cause, bss_pkg::CAUSE_AIR_CLOSED);
    clear("welded air");
    i_heat_demand = 1'b1;
    wait_bit(4, 1'b1);
    i_undervoltage = 1'b1;
    cw(50);
    check("low mains fan", o_motor, 7'h0);
    i_undervoltage = 1'b0;
    wait_bit(4, 1'b1);
    $display("test low mains done");
    press(2000);
    check("short hold", o_alarm, 7'h0);
    press(3100);
    check("long hold", o_nv_cause, bss_pkg::CAUSE_MANUAL);
    clear("long press");
    i_heat_demand = 1'b1;
    wait_bit(4, 1'b1);
    cw($urandom_range(1500, 300));
    air_break = 1'b1;
    cw(2);
    check("air opened", o_nv_cause, bss_pkg::CAUSE_AIR_OPENED);
    clear("air opened");
    air_dly = 8'($urandom_range(250, 2));
    i_heat_demand = 1'b1;
    wait_bit(4, 1'b1);
    cw(air_dly + 18000);
    stray = 1'b1;
    cw(20);
    stray = 1'b0;
    check("early light", o_alarm, 7'h0);
    cw(1200);
    stray = 1'b1;
    cw(3);
    check("stray cause", o_nv_cause, bss_pkg::CAUSE_STRAY);
    clear("stray light");
    air_dly = 8'($urandom_range(250, 2));
    i_heat_demand = 1'b1;
    wait_bit(4, 1'b1);
    t = cyc;
    cw(3000);
    read_msg(code);
    check("purge code", code, bss_pkg::CODE_PREPURGE);
    wait_bit(3, 1'b1);
    near("purge time", cyc - t, air_dly + ms(bss_pkg::PREPURGE_S));
    t = cyc;
    wait_bit(2, 1'b1);
    near("pre-ignition", cyc - t, ms(bss_pkg::PREIGN_S));
    t = cyc;
    wait_bit(3, 1'b0);
    near("post-ignition", cyc - t, ms(bss_pkg::POSTIGN_S));
    wait_bit(1, 1'b1);
    near("stage two", cyc - t, ms(15));
    read_msg(code);
    check("run code", code, bss_pkg::CODE_RUN);
    fuel_ok = 1'b0;
    wait_bit(0, 1'b1);
    check("loss cause", o_nv_cause, bss_pkg::CAUSE_FLAME_LOSS);
    read_msg(code);
    check("lock code", code, bss_pkg::CODE_F_FLAME_LOSS);
    $display("test full run done");
    do_reset(nv_store);
    check("kept cause", o_alarm, 7'h1);
    $display("test power cycle done");
    tally_and_finish();
  end
endmodule
